// ==== src/ppf_pin_cell.sv ====
/*
 one generic port pin: peripheral or port selection, pull-up, drive and
 open-drain. assumes the owner settles directions and data.
*/
`timescale 1ns/1ps
module ppf_pin_cell (
   // selection
   input  wire logic periph_own,
   input  wire logic periph_oe,
   input  wire logic periph_out,
   // port registers
   input  wire logic port_dir,
   input  wire logic port_data,
   // pad options
   input  wire logic pull_req,
   input  wire logic wire_or,
   // pad
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_pullup
);
   logic oe_sel;
   logic val_sel;
   assign oe_sel  = periph_own ? periph_oe : port_dir;
   assign val_sel = periph_own ? periph_out : port_data;
   assign pad_out = val_sel;
   assign pad_oe  = oe_sel & ~(wire_or & val_sel);
   assign pad_pullup = pull_req & ~oe_sel;
endmodule

// ==== src/ppf_pkg.sv ====
/*
 pin function control package: bit positions, widths and reset values
 of the port control bits. assumes nothing of its surroundings.
*/
package ppf_pkg;
   localparam int          PORT_W        = 8;
   localparam int          PWM_CH        = 4;
   localparam int          CAN_RX_BIT    = 0;
   localparam int          CAN_TX_BIT    = 1;
   localparam int          I2C_SCL_BIT   = 7;
   localparam int          I2C_SDA_BIT   = 6;
   localparam int          I2C_FIXED_PU  = 6;
   localparam int          ASYNC_WO_LO   = 0;
   localparam int          ASYNC_WO_HI   = 3;
   localparam int          SYNC_WO_LO    = 4;
   localparam int          SYNC_WO_HI    = 7;
   localparam logic [7:0]  DIR_RESET     = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic        CTRL_RESET    = 1'b0;
   localparam logic [7:0]  I2C_PU_FIXED  = 8'h3f;
endpackage

// ==== src/ppf_port_pin_function_control.sv ====
/*
 pin function control for can, i2c, analog, pwm, serial and timer ports.
 assumes peripherals and the cpu side give synchronous control bits.
*/
// Behaviour
// - can transmit pin carries bus level, 0 dominant, 1 recessive.
// - can port bit 0 is receive, bit 1 is transmit.
// - i2c clock on port bit 7, data on bit 6.
// - i2c pins only pull low or release, forming wired-and.
// - disabled i2c releases its pins to general-purpose i/o.
// - i2c direction bit 1 output, 0 input, cleared at reset.
// - i2c pull-up bit for inputs, reset clear; pins 0-5 always pulled as inputs.
// - i2c low drive bit reduces drive, reset full, always accessible.
// - analog ports give eight input-only pins while a/d disabled.
// - converter power-up bit enables a/d on its analog port.
// - enabled pwm channel takes its pin over port data.
// - pwm direction bit 1 output, 0 input, cleared at reset.
// - pwm pull-up bit enables pulls on inputs, cleared at reset.
// - pwm low drive bit reduces drive, reset full drive.
// - serial pins are port i/o unless their serial function enabled.
// - async wire-or disables high side on serial pins 0 to 3.
// - sync wire-or disables high side on serial pins 4 to 7.
// - wire-or applies to serial and port output alike.
// - serial low drive bit reduces drive on all serial pins.
// - serial pull-up only on port inputs, never on outputs.
// - timer pins port i/o unless timer or accumulator owns them.
// - timer direction bit 1 output, 0 input, cleared at reset.
`timescale 1ns/1ps
module ppf_port_pin_function_control (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // can channels
   input  wire logic [2:0]               can_transmit,
   output logic      [2:0]               can_receive,
   output logic      [2:0][1:0]          can_pad_out,
   input  wire logic [2:0][1:0]          can_pad_in,
   // i2c peripheral
   input  wire logic                     i2c_enable,
   input  wire logic                     i2c_scl_drive_low,
   input  wire logic                     i2c_sda_drive_low,
   output logic                          i2c_scl_in,
   output logic                          i2c_sda_in,
   // i2c port registers
   input  wire logic                     i2c_port_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] i2c_port_wdata,
   input  wire logic                     i2c_port_direction_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] i2c_port_direction_wdata,
   input  wire logic                     i2c_port_pad_config_write,
   input  wire logic                     i2c_port_pullup_enable_wdata,
   input  wire logic                     i2c_port_low_drive_wdata,
   output logic [ppf_pkg::PORT_W-1:0]    i2c_port_direction,
   output logic                          i2c_port_pullup_enable,
   output logic                          i2c_port_low_drive,
   // i2c port pads
   input  wire logic [ppf_pkg::PORT_W-1:0] i2c_pad_in,
   output logic [ppf_pkg::PORT_W-1:0]    i2c_pad_out,
   output logic [ppf_pkg::PORT_W-1:0]    i2c_pad_oe,
   output logic [ppf_pkg::PORT_W-1:0]    i2c_pad_pullup,
   output logic                          i2c_pad_low_drive,
   output logic [ppf_pkg::PORT_W-1:0]    i2c_port_read,
   // analog ports
   input  wire logic                     converter0_power_up,
   input  wire logic                     converter1_power_up,
   input  wire logic [ppf_pkg::PORT_W-1:0] analog0_pad_in,
   input  wire logic [ppf_pkg::PORT_W-1:0] analog1_pad_in,
   output logic [ppf_pkg::PORT_W-1:0]    analog0_port_read,
   output logic [ppf_pkg::PORT_W-1:0]    analog1_port_read,
   output logic                          analog0_select,
   output logic                          analog1_select,
   // pwm peripheral and port
   input  wire logic [ppf_pkg::PWM_CH-1:0] pwm_channel_enables,
   input  wire logic [ppf_pkg::PWM_CH-1:0] pwm_wave,
   input  wire logic                     pwm_port_write,
   input  wire logic [ppf_pkg::PWM_CH-1:0] pwm_port_wdata,
   input  wire logic                     pwm_port_direction_write,
   input  wire logic [ppf_pkg::PWM_CH-1:0] pwm_port_direction_wdata,
   input  wire logic                     pwm_control_write,
   input  wire logic                     pwm_port_pullup_enable_wdata,
   input  wire logic                     pwm_port_low_drive_wdata,
   output logic [ppf_pkg::PWM_CH-1:0]    pwm_port_direction,
   output logic                          pwm_port_pullup_enable,
   output logic                          pwm_port_low_drive,
   input  wire logic [ppf_pkg::PWM_CH-1:0] pwm_pad_in,
   output logic [ppf_pkg::PWM_CH-1:0]    pwm_pad_out,
   output logic [ppf_pkg::PWM_CH-1:0]    pwm_pad_oe,
   output logic [ppf_pkg::PWM_CH-1:0]    pwm_pad_pullup,
   output logic                          pwm_pad_low_drive,
   output logic [ppf_pkg::PWM_CH-1:0]    pwm_port_read,
   // serial peripherals and port
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_own,
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_oe,
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_out,
   input  wire logic                     async_wire_or_select,
   input  wire logic                     sync_wire_or_select,
   input  wire logic                     serial_port_low_drive,
   input  wire logic                     serial_port_pullup_enable,
   input  wire logic                     serial_port_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_port_wdata,
   input  wire logic                     serial_port_direction_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_port_direction_wdata,
   output logic [ppf_pkg::PORT_W-1:0]    serial_port_direction,
   input  wire logic [ppf_pkg::PORT_W-1:0] serial_pad_in,
   output logic [ppf_pkg::PORT_W-1:0]    serial_pad_out,
   output logic [ppf_pkg::PORT_W-1:0]    serial_pad_oe,
   output logic [ppf_pkg::PORT_W-1:0]    serial_pad_pullup,
   output logic                          serial_pad_low_drive,
   output logic [ppf_pkg::PORT_W-1:0]    serial_port_read,
   // timer peripheral and port
   input  wire logic                     timer_run_enable,
   input  wire logic                     pulse_accum_enable,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_chan_own,
   input  wire logic [ppf_pkg::PORT_W-1:0] accum_chan_own,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_oe,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_out,
   input  wire logic                     timer_port_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_port_wdata,
   input  wire logic                     timer_port_direction_write,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_port_direction_wdata,
   output logic [ppf_pkg::PORT_W-1:0]    timer_port_direction,
   input  wire logic [ppf_pkg::PORT_W-1:0] timer_pad_in,
   output logic [ppf_pkg::PORT_W-1:0]    timer_pad_out,
   output logic [ppf_pkg::PORT_W-1:0]    timer_pad_oe,
   output logic [ppf_pkg::PORT_W-1:0]    timer_port_read
);
   import ppf_pkg::*;

   typedef struct packed {
      logic [PORT_W-1:0] i2c_dir;
      logic [PORT_W-1:0] i2c_data;
      logic              i2c_pu;
      logic              i2c_rd;
      logic [PWM_CH-1:0] pwm_dir;
      logic [PWM_CH-1:0] pwm_data;
      logic              pwm_pu;
      logic              pwm_rd;
      logic [PORT_W-1:0] ser_dir;
      logic [PORT_W-1:0] ser_data;
      logic [PORT_W-1:0] tim_dir;
      logic [PORT_W-1:0] tim_data;
   } ppf_state_type;

   ppf_state_type     st;
   ppf_state_type     next_st;
   logic [PORT_W-1:0] i2c_own;
   logic [PORT_W-1:0] i2c_drv_low;
   logic [PORT_W-1:0] wo_mask;
   logic [PORT_W-1:0] tim_own;

   always_comb begin
      next_st = st;
      if (i2c_port_direction_write) begin
         next_st.i2c_dir = i2c_port_direction_wdata;
      end
      if (i2c_port_write) begin
         next_st.i2c_data = i2c_port_wdata;
      end
      if (i2c_port_pad_config_write) begin
         next_st.i2c_pu = i2c_port_pullup_enable_wdata;
         next_st.i2c_rd = i2c_port_low_drive_wdata;
      end
      if (pwm_port_direction_write) begin
         next_st.pwm_dir = pwm_port_direction_wdata;
      end
      if (pwm_port_write) begin
         next_st.pwm_data = pwm_port_wdata;
      end
      if (pwm_control_write) begin
         next_st.pwm_pu = pwm_port_pullup_enable_wdata;
         next_st.pwm_rd = pwm_port_low_drive_wdata;
      end
      if (serial_port_direction_write) begin
         next_st.ser_dir = serial_port_direction_wdata;
      end
      if (serial_port_write) begin
         next_st.ser_data = serial_port_wdata;
      end
      if (timer_port_direction_write) begin
         next_st.tim_dir = timer_port_direction_wdata;
      end
      if (timer_port_write) begin
         next_st.tim_data = timer_port_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st.i2c_dir  <= DIR_RESET;
         st.pwm_dir  <= DIR_RESET[PWM_CH-1:0];
         st.ser_dir  <= DIR_RESET;
         st.tim_dir  <= DIR_RESET;
         st.i2c_data <= DATA_RESET;
         st.pwm_data <= DATA_RESET[PWM_CH-1:0];
         st.ser_data <= DATA_RESET;
         st.tim_data <= DATA_RESET;
         st.i2c_pu   <= CTRL_RESET;
         st.pwm_pu   <= CTRL_RESET;
         st.i2c_rd   <= CTRL_RESET;
         st.pwm_rd   <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      for (int c = 0; c < 3; c++) begin
         can_pad_out[c]             = 2'b00;
         can_pad_out[c][CAN_TX_BIT] = can_transmit[c];
         can_receive[c]             = can_pad_in[c][CAN_RX_BIT];
      end
   end

   // i2c owns bits 7 and 6 only while enabled
   always_comb begin
      i2c_own                = '0;
      i2c_drv_low            = '0;
      i2c_own[I2C_SCL_BIT]   = i2c_enable;
      i2c_own[I2C_SDA_BIT]   = i2c_enable;
      i2c_drv_low[I2C_SCL_BIT] = i2c_scl_drive_low;
      i2c_drv_low[I2C_SDA_BIT] = i2c_sda_drive_low;
   end

   always_comb begin
      wo_mask = '0;
      for (int i = ASYNC_WO_LO; i <= ASYNC_WO_HI; i++) begin
         wo_mask[i] = async_wire_or_select;
      end
      for (int i = SYNC_WO_LO; i <= SYNC_WO_HI; i++) begin
         wo_mask[i] = sync_wire_or_select;
      end
   end

   assign tim_own = (timer_chan_own & {PORT_W{timer_run_enable}})
                  | (accum_chan_own & {PORT_W{pulse_accum_enable}});

   genvar g;
   generate
      for (g = 0; g < PORT_W; g++) begin : g_pin
         logic i2c_pull;
         assign i2c_pull = st.i2c_pu | I2C_PU_FIXED[g];
         // i2c drives low only, port side unaffected
         ppf_pin_cell u_i2c (
            .periph_own (i2c_own[g]),
            .periph_oe  (i2c_drv_low[g]),
            .periph_out (1'b0),
            .port_dir   (st.i2c_dir[g]),
            .port_data  (st.i2c_data[g]),
            .pull_req   (i2c_pull | i2c_own[g]),
            .wire_or    (1'b0),
            .pad_out    (i2c_pad_out[g]),
            .pad_oe     (i2c_pad_oe[g]),
            .pad_pullup (i2c_pad_pullup[g])
         );
         ppf_pin_cell u_ser (
            .periph_own (serial_own[g]),
            .periph_oe  (serial_oe[g]),
            .periph_out (serial_out[g]),
            .port_dir   (st.ser_dir[g]),
            .port_data  (st.ser_data[g]),
            .pull_req   (serial_port_pullup_enable & ~serial_own[g]),
            .wire_or    (wo_mask[g]),
            .pad_out    (serial_pad_out[g]),
            .pad_oe     (serial_pad_oe[g]),
            .pad_pullup (serial_pad_pullup[g])
         );
         ppf_pin_cell u_tim (
            .periph_own (tim_own[g]),
            .periph_oe  (timer_oe[g]),
            .periph_out (timer_out[g]),
            .port_dir   (st.tim_dir[g]),
            .port_data  (st.tim_data[g]),
            .pull_req   (1'b0),
            .wire_or    (1'b0),
            .pad_out    (timer_pad_out[g]),
            .pad_oe     (timer_pad_oe[g]),
            .pad_pullup ()
         );
      end
      for (g = 0; g < PWM_CH; g++) begin : g_pwm
         ppf_pin_cell u_pwm (
            .periph_own (pwm_channel_enables[g]),
            .periph_oe  (1'b1),
            .periph_out (pwm_wave[g]),
            .port_dir   (st.pwm_dir[g]),
            .port_data  (st.pwm_data[g]),
            .pull_req   (st.pwm_pu),
            .wire_or    (1'b0),
            .pad_out    (pwm_pad_out[g]),
            .pad_oe     (pwm_pad_oe[g]),
            .pad_pullup (pwm_pad_pullup[g])
         );
      end
   endgenerate

   // analog ports input only, zero while powered up
   assign analog0_select    = converter0_power_up;
   assign analog1_select    = converter1_power_up;
   assign analog0_port_read = converter0_power_up ? '0 : analog0_pad_in;
   assign analog1_port_read = converter1_power_up ? '0 : analog1_pad_in;

   // pad levels are read back, direction does not gate reads
   assign i2c_scl_in       = i2c_pad_in[I2C_SCL_BIT];
   assign i2c_sda_in       = i2c_pad_in[I2C_SDA_BIT];
   assign i2c_port_read    = i2c_pad_in;
   assign pwm_port_read    = pwm_pad_in;
   assign serial_port_read = serial_pad_in;
   assign timer_port_read  = timer_pad_in;

   assign i2c_pad_low_drive    = st.i2c_rd;
   assign pwm_pad_low_drive    = st.pwm_rd;
   assign serial_pad_low_drive = serial_port_low_drive;

   assign i2c_port_direction     = st.i2c_dir;
   assign i2c_port_pullup_enable = st.i2c_pu;
   assign i2c_port_low_drive     = st.i2c_rd;
   assign pwm_port_direction     = st.pwm_dir;
   assign pwm_port_pullup_enable = st.pwm_pu;
   assign pwm_port_low_drive     = st.pwm_rd;
   assign serial_port_direction  = st.ser_dir;
   assign timer_port_direction   = st.tim_dir;
endmodule

// ==== verification/ppf_pad_world.sv ====
/*
 far-side model of the pads: resolves each pin from the device drive,
 an open-drain external driver and the internal pull-up.
 assumes one instance per port on the core clock.
*/
`timescale 1ns/1ps
module ppf_pad_world #(
   parameter int W = 8
) (
   // clock
   input  wire logic         clk,
   // device side
   input  wire logic [W-1:0] pad_out,
   input  wire logic [W-1:0] pad_oe,
   input  wire logic [W-1:0] pad_pullup,
   // external open-drain driver
   input  wire logic [W-1:0] ext_low,
   output logic      [W-1:0] pad_in
);
   logic toggle = 1'b0;
   // a floating pin wanders, so no read can pass by luck
   always @(posedge clk) begin
      toggle <= ~toggle;
   end
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (ext_low[i] || (pad_oe[i] && !pad_out[i])) pad_in[i] = 1'b0;
         else if (pad_oe[i] || pad_pullup[i]) pad_in[i] = 1'b1;
         else pad_in[i] = toggle;
      end
   end
endmodule

// ==== verification/ppf_pin_assertions.sv ====
/*
 concurrent checks on the pin function control ports.
 assumes binding to the top module, one clock, sync reset.
*/
`timescale 1ns/1ps
module ppf_pin_assertions (
   // clock and reset
   input wire logic            clk, sys_rst,
   // controls
   input wire logic            i2c_enable, i2c_scl_drive_low, i2c_sda_drive_low,
   input wire logic            i2c_port_direction_write, i2c_port_pad_config_write,
   input wire logic            i2c_port_low_drive_wdata, i2c_port_low_drive,
   input wire logic            async_wire_or_select, sync_wire_or_select,
   input wire logic            converter0_power_up, analog0_select,
   // vectors
   input wire logic [2:0]      can_transmit, can_receive,
   input wire logic [2:0][1:0] can_pad_out, can_pad_in,
   input wire logic [7:0]      i2c_port_direction_wdata, i2c_port_direction,
   input wire logic [7:0]      i2c_pad_out, i2c_pad_oe, i2c_pad_pullup,
   input wire logic [7:0]      serial_pad_out, serial_pad_oe, serial_pad_pullup,
   input wire logic [7:0]      analog0_pad_in, analog0_port_read,
   input wire logic [3:0]      pwm_channel_enables, pwm_wave, pwm_pad_out, pwm_pad_oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   property p_can_tx;
      {can_pad_out[2][1], can_pad_out[1][1], can_pad_out[0][1]} == can_transmit;
   endproperty
   a_can_tx: assert property (p_can_tx) else $error("can tx level wrong");
   property p_can_rx;
      can_receive == {can_pad_in[2][0], can_pad_in[1][0], can_pad_in[0][0]};
   endproperty
   a_can_rx: assert property (p_can_rx) else $error("can rx bit wrong");
   property p_i2c_own;
      i2c_enable |-> i2c_pad_oe[7:6] == {i2c_scl_drive_low, i2c_sda_drive_low}
         && (i2c_pad_oe[7:6] & i2c_pad_out[7:6]) == 2'h0;
   endproperty
   a_i2c_own: assert property (p_i2c_own) else $error("i2c pin drive wrong");
   property p_i2c_gpio;
      !i2c_enable |-> i2c_pad_oe == i2c_port_direction;
   endproperty
   a_i2c_gpio: assert property (p_i2c_gpio) else $error("i2c gpio oe wrong");
   property p_dir_load;
      i2c_port_direction_write |=> i2c_port_direction == $past(i2c_port_direction_wdata);
   endproperty
   a_dir_load: assert property (p_dir_load) else $error("i2c dir load wrong");
   property p_fixed_pull;
      i2c_pad_pullup[5:0] == ~i2c_pad_oe[5:0];
   endproperty
   a_fixed_pull: assert property (p_fixed_pull) else $error("i2c fixed pull wrong");
   property p_low_drive;
      i2c_port_pad_config_write |=> i2c_port_low_drive == $past(i2c_port_low_drive_wdata);
   endproperty
   a_low_drive: assert property (p_low_drive) else $error("i2c low drive wrong");
   property p_pwm_take;
      (pwm_pad_oe & pwm_channel_enables) == pwm_channel_enables
         && ((pwm_pad_out ^ pwm_wave) & pwm_channel_enables) == 4'h0;
   endproperty
   a_pwm_take: assert property (p_pwm_take) else $error("pwm pin not taken");
   property p_wire_or;
      (serial_pad_oe & serial_pad_out
         & {{4{sync_wire_or_select}}, {4{async_wire_or_select}}}) == 8'h00;
   endproperty
   a_wire_or: assert property (p_wire_or) else $error("wire-or high drive");
   property p_ser_pull;
      (serial_pad_pullup & serial_pad_oe) == 8'h00;
   endproperty
   a_ser_pull: assert property (p_ser_pull) else $error("serial pull on output");
   property p_analog;
      analog0_select == converter0_power_up
         && (converter0_power_up || analog0_port_read == analog0_pad_in);
   endproperty
   a_analog: assert property (p_analog) else $error("analog port wrong");
   c_i2c_low: cover property (i2c_enable && i2c_sda_drive_low);
   c_wire_or: cover property (async_wire_or_select && serial_pad_oe != 8'h00);
   c_pwm: cover property (pwm_channel_enables != 4'h0);
endmodule
bind ppf_port_pin_function_control ppf_pin_assertions u_chk (.*);

// ==== verification/tb.sv ====
/*
 self-checking bench for the pin function control block.
 assumes the pad model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module tb;
   import ppf_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, wr_all = 1'b0;
   logic i2c_enable = '0, i2c_scl_drive_low = '0, i2c_sda_drive_low = '0;
   logic converter0_power_up = '0, converter1_power_up = '0, timer_run_enable = '0;
   logic pulse_accum_enable = '0, async_wire_or_select = '0, sync_wire_or_select = '0;
   logic serial_port_low_drive = '0, serial_port_pullup_enable = '0;
   logic i2c_port_pullup_enable_wdata = '0, i2c_port_low_drive_wdata = '0;
   logic pwm_port_pullup_enable_wdata = '0, pwm_port_low_drive_wdata = '0;
   logic i2c_port_write, i2c_port_direction_write, i2c_port_pad_config_write, pwm_port_write;
   logic pwm_port_direction_write, pwm_control_write, serial_port_write, timer_port_write;
   logic serial_port_direction_write, timer_port_direction_write;
   logic [7:0] i2c_port_wdata = '0, i2c_port_direction_wdata = '0, i2c_ext_low = '0;
   logic [7:0] analog0_pad_in = '0, analog1_pad_in = 8'h69, serial_own = '0, serial_oe = '0;
   logic [7:0] serial_out = '0, serial_port_wdata = '0, serial_port_direction_wdata = '0;
   logic [7:0] timer_chan_own = '0, accum_chan_own = '0, timer_oe = '0, timer_out = '0;
   logic [7:0] timer_port_wdata = '0, timer_port_direction_wdata = '0, ext_low = '0;
   logic [3:0] pwm_channel_enables = '0, pwm_wave = '0, pwm_port_wdata = '0;
   logic [3:0] pwm_port_direction_wdata = '0;
   logic [2:0] can_transmit = '0, can_receive;
   logic [2:0][1:0] can_pad_in = '0, can_pad_out;
   logic i2c_scl_in, i2c_sda_in, i2c_port_pullup_enable, i2c_port_low_drive, i2c_pad_low_drive;
   logic analog0_select, analog1_select, pwm_port_pullup_enable, pwm_port_low_drive;
   logic pwm_pad_low_drive, serial_pad_low_drive;
   logic [7:0] i2c_port_direction, i2c_pad_in, i2c_pad_out, i2c_pad_oe, i2c_pad_pullup;
   logic [7:0] i2c_port_read, analog0_port_read, analog1_port_read, serial_port_direction;
   logic [7:0] serial_pad_in, serial_pad_out, serial_pad_oe, serial_pad_pullup;
   logic [7:0] serial_port_read, timer_port_direction, timer_pad_in, timer_pad_out;
   logic [7:0] timer_pad_oe, timer_port_read;
   logic [3:0] pwm_port_direction, pwm_pad_in, pwm_pad_out, pwm_pad_oe, pwm_pad_pullup;
   logic [3:0] pwm_port_read;
   int error_cnt = 0;
   int checks_done = 0;
   // one strobe loads every port register in the same cycle
   assign {i2c_port_write, i2c_port_direction_write, i2c_port_pad_config_write, pwm_port_write,
      pwm_port_direction_write, pwm_control_write, serial_port_write, timer_port_write,
      serial_port_direction_write, timer_port_direction_write} = {10{wr_all}};
   always #2.5 clk = ~clk;
   ppf_port_pin_function_control u_dut (.*);
   ppf_pad_world #(.W(8)) u_i2c (.clk(clk), .pad_out(i2c_pad_out), .pad_oe(i2c_pad_oe),
      .pad_pullup(i2c_pad_pullup), .ext_low(i2c_ext_low), .pad_in(i2c_pad_in));
   ppf_pad_world #(.W(4)) u_pwm (.clk(clk), .pad_out(pwm_pad_out), .pad_oe(pwm_pad_oe),
      .pad_pullup(pwm_pad_pullup), .ext_low(ext_low[3:0]), .pad_in(pwm_pad_in));
   ppf_pad_world #(.W(8)) u_ser (.clk(clk), .pad_out(serial_pad_out), .pad_oe(serial_pad_oe),
      .pad_pullup(serial_pad_pullup), .ext_low(ext_low), .pad_in(serial_pad_in));
   ppf_pad_world #(.W(8)) u_tmr (.clk(clk), .pad_out(timer_pad_out), .pad_oe(timer_pad_oe),
      .pad_pullup(8'h00), .ext_low(ext_low), .pad_in(timer_pad_in));
   task automatic wr_regs(input logic [7:0] dir, dat, input logic pu, ld);
      @(posedge clk);
      wr_all <= 1'b1;
      {i2c_port_direction_wdata, serial_port_direction_wdata} <= {dir, dir};
      {timer_port_direction_wdata, pwm_port_direction_wdata} <= {dir, dir[3:0]};
      {i2c_port_wdata, serial_port_wdata} <= {dat, dat};
      {timer_port_wdata, pwm_port_wdata} <= {dat, dat[3:0]};
      {i2c_port_pullup_enable_wdata, pwm_port_pullup_enable_wdata} <= {pu, pu};
      {i2c_port_low_drive_wdata, pwm_port_low_drive_wdata} <= {ld, ld};
      @(posedge clk);
      wr_all <= 1'b0;
      #1;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // whole run is under 100 cycles; ten times that is a hang
   initial begin
      #5000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      serial_port_pullup_enable <= 1'b1;
      #1;
      chk(i2c_port_direction, 8'h00);
      chk(pwm_port_direction, 8'h00);
      chk(timer_port_direction, 8'h00);
      chk({i2c_port_pullup_enable, pwm_port_pullup_enable}, 8'h00);
      chk({i2c_port_low_drive, pwm_port_low_drive}, 8'h00);
      chk(i2c_pad_pullup, 8'h3f);
      $display("test reset done");
      wr_regs(8'ha5, 8'h3c, 1'b0, 1'b0);
      chk(i2c_pad_oe, 8'ha5);
      chk(pwm_pad_oe, 8'h05);
      chk(timer_pad_oe, 8'ha5);
      chk(serial_pad_oe, 8'ha5);
      chk(serial_port_direction, 8'ha5);
      chk(i2c_pad_out & i2c_pad_oe, 8'h24);
      chk(i2c_pad_pullup, 8'h1a);
      chk(serial_pad_pullup, 8'h5a);
      chk(i2c_port_read & 8'hbf, 8'h3e);
      wr_regs(8'ha5, 8'h3c, 1'b1, 1'b1);
      chk(i2c_pad_pullup, 8'h5a);
      chk(pwm_pad_pullup, 8'h0a);
      chk({i2c_pad_low_drive, pwm_pad_low_drive}, 8'h03);
      chk(i2c_port_read, 8'h7e);
      $display("test port registers done");
      @(posedge clk);
      i2c_enable <= 1'b1;
      i2c_sda_drive_low <= 1'b1;
      #1;
      chk(i2c_pad_oe, 8'h65);
      chk(i2c_pad_out & 8'hc0, 8'h00);
      chk({i2c_scl_in, i2c_sda_in}, 8'h02);
      @(posedge clk);
      i2c_ext_low <= 8'h80;
      #1;
      chk({i2c_scl_in, i2c_sda_in}, 8'h00);
      @(posedge clk);
      i2c_enable <= 1'b0;
      i2c_ext_low <= 8'h00;
      #1;
      chk(i2c_pad_oe, 8'ha5);
      $display("test i2c done");
      @(posedge clk);
      pwm_channel_enables <= 4'ha;
      pwm_wave <= 4'h2;
      #1;
      chk(pwm_pad_oe, 8'h0f);
      chk(pwm_pad_out, 8'h06);
      chk(pwm_port_read, 8'h06);
      $display("test pwm done");
      @(posedge clk);
      {serial_own, serial_oe, serial_out} <= {8'hf0, 8'hff, 8'h50};
      #1;
      chk(serial_pad_oe, 8'hf5);
      chk(serial_pad_out & serial_pad_oe, 8'h54);
      @(posedge clk);
      {async_wire_or_select, sync_wire_or_select, serial_port_low_drive} <= 3'h7;
      ext_low <= 8'h04;
      #1;
      chk(serial_pad_oe, 8'ha1);
      chk(serial_port_read & 8'h2f, 8'h0a);
      chk(serial_pad_low_drive, 8'h01);
      $display("test serial done");
      @(posedge clk);
      {timer_chan_own, accum_chan_own, timer_oe, timer_out} <= {8'h0f, 8'hf0, 8'h33, 8'hff};
      timer_run_enable <= 1'b1;
      ext_low <= 8'h00;
      #1;
      chk(timer_pad_oe, 8'ha3);
      @(posedge clk);
      {timer_run_enable, pulse_accum_enable} <= 2'h1;
      #1;
      chk(timer_pad_oe, 8'h35);
      chk(timer_pad_out & timer_pad_oe, 8'h34);
      chk(timer_port_read & 8'h35, 8'h34);
      $display("test timer done");
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         can_transmit <= c[2:0];
         can_pad_in <= {1'b0, ~c[2], 1'b1, ~c[1], 1'b0, ~c[0]};
         {converter0_power_up, converter1_power_up} <= c[1:0];
         analog0_pad_in <= 8'h96;
         #1;
         chk(can_pad_out, {2'h0, c[2], 1'b0, c[1], 1'b0, c[0], 1'b0});
         chk(can_receive, {5'h00, ~c[2:0]});
         chk(analog0_port_read, c[1] ? 8'h00 : 8'h96);
         chk(analog1_port_read, c[0] ? 8'h00 : 8'h69);
         chk({analog0_select, analog1_select}, {6'h00, c[1:0]});
      end
      $display("test can and analog done");
      wrap_up();
   end
endmodule
